// File: hw/flag_defines.svh
// bit positions, register offsets and constants of the condition flag block
// assumes nothing beyond a SystemVerilog compiler that honours include guards
`ifndef FLAG_DEFINES_SVH
`define FLAG_DEFINES_SVH

`define FL_SIGN 7
`define FL_ZERO 6
`define FL_HALF 4
`define FL_PV 2
`define FL_SUB 1
`define FL_CARRY 0

`define FLAGS_RESET 8'h00
`define FLAGS_LIVE_MASK 8'hd7

`define OFF_MAIN_FLAGS 4'h0
`define OFF_ALT_FLAGS 4'h4
`define OFF_STATUS 4'h8

`define BCD_LOW_FIX 8'h06
`define BCD_HIGH_FIX 8'h60
`define BCD_DIGIT_MAX 4'h9
`define BCD_BYTE_MAX 8'h99

`endif

// File: hw/flag_pkg.sv
// types shared by the condition flag block and whoever drives it
// assumes the decoder presents one flag_op_t per clock-enabled cycle
package flag_pkg;

    typedef enum logic [4:0] {
        OP_ADD8 = 5'h00, OP_ADC8 = 5'h01, OP_SUB8 = 5'h02, OP_SBC8 = 5'h03,
        OP_CP8 = 5'h04, OP_NEG8 = 5'h05, OP_AND8 = 5'h06, OP_OR8 = 5'h07,
        OP_XOR8 = 5'h08, OP_INC8 = 5'h09, OP_DEC8 = 5'h0a, OP_ADD16 = 5'h0b,
        OP_ADC16 = 5'h0c, OP_SBC16 = 5'h0d, OP_ROT_ACC = 5'h0e, OP_ROT_LOC = 5'h0f,
        OP_NIB_LEFT = 5'h10, OP_NIB_RIGHT = 5'h11, OP_DEC_ADJ = 5'h12, OP_CPL = 5'h13,
        OP_SCF = 5'h14, OP_CCF = 5'h15, OP_IN_REG = 5'h16, OP_BLK_IO = 5'h17,
        OP_BLK_MOVE = 5'h18, OP_BLK_CMP = 5'h19, OP_LD_IR = 5'h1a, OP_BIT = 5'h1b
    } flag_op_e_t;

    typedef enum logic [2:0] {
        ROT_RLC = 3'h0, ROT_RRC = 3'h1, ROT_RL = 3'h2, ROT_RR = 3'h3,
        ROT_SLA = 3'h4, ROT_SRA = 3'h5, ROT_SRL = 3'h6
    } rot_kind_t;

    typedef enum logic [2:0] {
        COND_NZ = 3'h0, COND_Z = 3'h1, COND_NC = 3'h2, COND_C = 3'h3,
        COND_PO = 3'h4, COND_PE = 3'h5, COND_P = 3'h6, COND_M = 3'h7
    } cond_t;

    typedef struct packed {
        logic valid;
        flag_op_e_t op;
        rot_kind_t rot;
        logic [2:0] bit_sel;
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] a16;
        logic [15:0] b16;
        logic [15:0] block_count_pair;
        logic [7:0] io_count;
        logic interrupt_enable_latch;
        logic swap;
    } flag_op_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic h;
        logic v;
    } alu8_t;

    typedef struct packed {
        logic [15:0] res;
        logic c;
        logic v;
    } alu16_t;

    typedef struct packed {
        logic [7:0] main_flags;
        logic [7:0] alt_flags;
        logic bank;
        logic ack;
        logic [31:0] rdata;
        logic [15:0] result;
    } flag_state_t;

endpackage : flag_pkg

// File: hw/cpu_condition_flag_logic.sv
// condition flag generation and update for an 8-bit processor core
// assumes a decoder issuing flag_op_i synchronously and a classic wishbone master
//
// Function
// - two flag bytes, main and alternate
// - S, Z, P/V, C drive branch conditions
// - add and shifts load carry out
// - subtract borrow sets carry
// - zero flag marks zero result
// - sign flag copies result bit 7, or bit 15 on 16-bit add/subtract with carry
// - P/V flags signed overflow on arithmetic
// - logic ops: parity, N C clear, H
// - half-carry tracks low nibble carry/borrow
// - N records add versus subtract
// - other instructions leave flags untouched
// - block compare: Z on match, N set
// - block compare/move: P/V while count nonzero
// - block I/O: Z when count zero, N
// - load vector/refresh copies interrupt latch
// - 8-bit add flags, N cleared
// - 8-bit subtract family flags, N set
// - 16-bit add-with-carry flags, N cleared
// - 16-bit subtract-with-carry flags, N set
// - location rotates: S Z P, carry out
// - nibble rotates: S Z P, carry kept
// - bit test into Z, H set
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`include "flag_defines.svh"

module cpu_condition_flag_logic
    import flag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire flag_op_t flag_op_i,
    input wire cond_t cond_sel_i,
    output logic cond_true_o,
    output logic [7:0] flags_o,
    output logic [15:0] result_o,
    output logic bank_o
);

    flag_state_t st_reg;
    flag_state_t st_next;

    function automatic alu8_t add8(input logic [7:0] x, input logic [7:0] y, input logic cin);
        alu8_t r;
        logic [8:0] s;
        logic [4:0] l;
        s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        l = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        r.res = s[7:0];
        r.c = s[8];
        r.h = l[4];
        r.v = (x[7] == y[7]) && (s[7] != x[7]);
        return r;
    endfunction : add8

    function automatic alu8_t sub8(input logic [7:0] x, input logic [7:0] y, input logic cin);
        alu8_t r;
        logic [8:0] s;
        logic [4:0] l;
        s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        l = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
        r.res = s[7:0];
        r.c = s[8];
        r.h = l[4];
        r.v = (x[7] != y[7]) && (s[7] != x[7]);
        return r;
    endfunction : sub8

    function automatic alu16_t arith16(input logic [15:0] x, input logic [15:0] y,
                                       input logic cin, input logic subtract);
        alu16_t r;
        logic [16:0] s;
        if (subtract) begin
            s = {1'b0, x} - {1'b0, y} - {16'h0000, cin};
            r.v = (x[15] != y[15]) && (s[15] != x[15]);
        end else begin
            s = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
            r.v = (x[15] == y[15]) && (s[15] != x[15]);
        end
        r.res = s[15:0];
        r.c = s[16];
        return r;
    endfunction : arith16

    // parity flag convention: 1 for an even count of ones
    function automatic logic [7:0] szp(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] o;
        o = f;
        o[`FL_SIGN] = r[7];
        o[`FL_ZERO] = (r == 8'h00);
        o[`FL_PV] = ~^r;
        return o;
    endfunction : szp

    function automatic logic [8:0] rotate(input rot_kind_t k, input logic [7:0] v,
                                          input logic cin);
        logic [8:0] o;
        unique case (k)
            ROT_RLC: o = {v[7], v[6:0], v[7]};
            ROT_RRC: o = {v[0], v[0], v[7:1]};
            ROT_RL: o = {v[7], v[6:0], cin};
            ROT_RR: o = {v[0], cin, v[7:1]};
            ROT_SLA: o = {v[7], v[6:0], 1'b0};
            ROT_SRA: o = {v[0], v[7], v[7:1]};
            ROT_SRL: o = {v[0], 1'b0, v[7:1]};
            default: o = {1'b0, v};
        endcase
        return o;
    endfunction : rotate

    logic [7:0] act_flags;
    logic cin;
    logic bus_req;
    logic bus_wr;

    assign act_flags = st_reg.bank ? st_reg.alt_flags : st_reg.main_flags;
    assign cin = act_flags[`FL_CARRY];
    assign bus_req = wb_cyc_i && wb_stb_i;
    // a write commits at the edge where the master sees ack
    assign bus_wr = bus_req && wb_we_i && st_reg.ack && wb_sel_i[0];

    always_comb begin
        alu8_t a8;
        alu16_t a16;
        logic [8:0] rt;
        logic [7:0] nf;
        logic [7:0] r8;
        logic [7:0] corr;
        st_next = st_reg;
        nf = act_flags;
        r8 = flag_op_i.a;
        corr = 8'h00;
        a8 = add8(flag_op_i.a, flag_op_i.b, 1'b0);
        a16 = arith16(flag_op_i.a16, flag_op_i.b16, cin, 1'b0);
        rt = rotate(flag_op_i.rot, flag_op_i.b, cin);
        // indeterminate flags keep their previous value
        unique case (flag_op_i.op)
            OP_ADD8, OP_ADC8: begin
                a8 = add8(flag_op_i.a, flag_op_i.b, (flag_op_i.op == OP_ADC8) && cin);
                r8 = a8.res;
                nf = szp(nf, r8);
                nf[`FL_PV] = a8.v;
                nf[`FL_HALF] = a8.h;
                nf[`FL_CARRY] = a8.c;
                nf[`FL_SUB] = 1'b0;
            end
            OP_SUB8, OP_SBC8, OP_CP8, OP_NEG8: begin
                if (flag_op_i.op == OP_NEG8) begin
                    a8 = sub8(8'h00, flag_op_i.a, 1'b0);
                end else begin
                    a8 = sub8(flag_op_i.a, flag_op_i.b, (flag_op_i.op == OP_SBC8) && cin);
                end
                r8 = (flag_op_i.op == OP_CP8) ? flag_op_i.a : a8.res;
                nf = szp(nf, a8.res);
                nf[`FL_PV] = a8.v;
                nf[`FL_HALF] = a8.h;
                nf[`FL_CARRY] = a8.c;
                nf[`FL_SUB] = 1'b1;
            end
            OP_AND8, OP_OR8, OP_XOR8: begin
                if (flag_op_i.op == OP_AND8) begin
                    r8 = flag_op_i.a & flag_op_i.b;
                end else if (flag_op_i.op == OP_OR8) begin
                    r8 = flag_op_i.a | flag_op_i.b;
                end else begin
                    r8 = flag_op_i.a ^ flag_op_i.b;
                end
                nf = szp(nf, r8);
                nf[`FL_HALF] = (flag_op_i.op == OP_AND8);
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = 1'b0;
            end
            OP_INC8, OP_DEC8: begin
                if (flag_op_i.op == OP_INC8) begin
                    a8 = add8(flag_op_i.b, 8'h01, 1'b0);
                end else begin
                    a8 = sub8(flag_op_i.b, 8'h01, 1'b0);
                end
                r8 = a8.res;
                nf = szp(nf, r8);
                nf[`FL_PV] = a8.v;
                nf[`FL_HALF] = a8.h;
                nf[`FL_SUB] = (flag_op_i.op == OP_DEC8);
            end
            OP_ADD16: begin
                a16 = arith16(flag_op_i.a16, flag_op_i.b16, 1'b0, 1'b0);
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = a16.c;
            end
            OP_ADC16, OP_SBC16: begin
                a16 = arith16(flag_op_i.a16, flag_op_i.b16, cin, flag_op_i.op == OP_SBC16);
                nf[`FL_SIGN] = a16.res[15];
                nf[`FL_ZERO] = (a16.res == 16'h0000);
                nf[`FL_PV] = a16.v;
                nf[`FL_CARRY] = a16.c;
                nf[`FL_SUB] = (flag_op_i.op == OP_SBC16);
            end
            OP_ROT_ACC: begin
                rt = rotate(flag_op_i.rot, flag_op_i.a, cin);
                r8 = rt[7:0];
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = rt[8];
            end
            OP_ROT_LOC: begin
                r8 = rt[7:0];
                nf = szp(nf, r8);
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = rt[8];
            end
            OP_NIB_LEFT, OP_NIB_RIGHT: begin
                // accumulator in the low byte of the result, memory byte in the high
                if (flag_op_i.op == OP_NIB_LEFT) begin
                    r8 = {flag_op_i.a[7:4], flag_op_i.b[7:4]};
                end else begin
                    r8 = {flag_op_i.a[7:4], flag_op_i.b[3:0]};
                end
                nf = szp(nf, r8);
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
            end
            OP_DEC_ADJ: begin
                if (act_flags[`FL_HALF] || (flag_op_i.a[3:0] > `BCD_DIGIT_MAX)) begin
                    corr = corr | `BCD_LOW_FIX;
                end
                if (act_flags[`FL_CARRY] || (flag_op_i.a > `BCD_BYTE_MAX)) begin
                    corr = corr | `BCD_HIGH_FIX;
                    nf[`FL_CARRY] = 1'b1;
                end
                // N picks the correction direction
                if (act_flags[`FL_SUB]) begin
                    r8 = flag_op_i.a - corr;
                    nf[`FL_HALF] = act_flags[`FL_HALF] && (flag_op_i.a[3:0] < 4'h6);
                end else begin
                    r8 = flag_op_i.a + corr;
                    nf[`FL_HALF] = (flag_op_i.a[3:0] > `BCD_DIGIT_MAX);
                end
                nf = szp(nf, r8);
            end
            OP_CPL: begin
                r8 = ~flag_op_i.a;
                nf[`FL_HALF] = 1'b1;
                nf[`FL_SUB] = 1'b1;
            end
            OP_SCF: begin
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = 1'b1;
            end
            OP_CCF: begin
                nf[`FL_SUB] = 1'b0;
                nf[`FL_CARRY] = ~cin;
            end
            OP_IN_REG: begin
                r8 = flag_op_i.b;
                nf = szp(nf, r8);
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
            end
            OP_BLK_IO: begin
                nf[`FL_ZERO] = (flag_op_i.io_count == 8'h00);
                nf[`FL_SUB] = 1'b1;
            end
            OP_BLK_MOVE: begin
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
                nf[`FL_PV] = (flag_op_i.block_count_pair != 16'h0000);
            end
            OP_BLK_CMP: begin
                a8 = sub8(flag_op_i.a, flag_op_i.b, 1'b0);
                nf[`FL_SIGN] = a8.res[7];
                nf[`FL_ZERO] = (flag_op_i.a == flag_op_i.b);
                nf[`FL_HALF] = a8.h;
                nf[`FL_SUB] = 1'b1;
                nf[`FL_PV] = (flag_op_i.block_count_pair != 16'h0000);
            end
            OP_LD_IR: begin
                r8 = flag_op_i.b;
                nf = szp(nf, r8);
                nf[`FL_PV] = flag_op_i.interrupt_enable_latch;
                nf[`FL_HALF] = 1'b0;
                nf[`FL_SUB] = 1'b0;
            end
            OP_BIT: begin
                nf[`FL_ZERO] = ~flag_op_i.b[flag_op_i.bit_sel];
                nf[`FL_HALF] = 1'b1;
                nf[`FL_SUB] = 1'b0;
            end
            default: begin
                nf = act_flags;
            end
        endcase
        nf = nf & `FLAGS_LIVE_MASK;

        if (ce_i) begin
            st_next.ack = bus_req && !st_reg.ack;
            if (bus_req && !st_reg.ack) begin
                unique case (wb_adr_i)
                    `OFF_MAIN_FLAGS: st_next.rdata = {24'h000000, st_reg.main_flags};
                    `OFF_ALT_FLAGS: st_next.rdata = {24'h000000, st_reg.alt_flags};
                    `OFF_STATUS: st_next.rdata = {31'h00000000, st_reg.bank};
                    default: st_next.rdata = 32'h00000000;
                endcase
            end
            if (bus_wr && (wb_adr_i == `OFF_MAIN_FLAGS)) begin
                st_next.main_flags = wb_dat_i[7:0] & `FLAGS_LIVE_MASK;
            end
            if (bus_wr && (wb_adr_i == `OFF_ALT_FLAGS)) begin
                st_next.alt_flags = wb_dat_i[7:0] & `FLAGS_LIVE_MASK;
            end
            // the instruction stream outranks a software write to the same byte
            if (flag_op_i.valid) begin
                if (st_reg.bank) begin
                    st_next.alt_flags = nf;
                end else begin
                    st_next.main_flags = nf;
                end
                st_next.result = (flag_op_i.op == OP_NIB_LEFT)
                    ? {flag_op_i.b[3:0], flag_op_i.a[3:0], r8}
                    : (flag_op_i.op == OP_NIB_RIGHT)
                    ? {flag_op_i.a[3:0], flag_op_i.b[7:4], r8}
                    : (flag_op_i.op inside {OP_ADD16, OP_ADC16, OP_SBC16})
                    ? a16.res : {8'h00, r8};
            end
            // exchange takes effect after this cycle's update
            if (flag_op_i.swap) begin
                st_next.bank = ~st_reg.bank;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '{main_flags: `FLAGS_RESET, alt_flags: `FLAGS_RESET, bank: 1'b0,
                        ack: 1'b0, rdata: 32'h00000000, result: 16'h0000};
        end else begin
            st_reg <= st_next;
        end
    end

    // H and N are deliberately not selectable here
    always_comb begin
        unique case (cond_sel_i)
            COND_NZ: cond_true_o = ~act_flags[`FL_ZERO];
            COND_Z: cond_true_o = act_flags[`FL_ZERO];
            COND_NC: cond_true_o = ~act_flags[`FL_CARRY];
            COND_C: cond_true_o = act_flags[`FL_CARRY];
            COND_PO: cond_true_o = ~act_flags[`FL_PV];
            COND_PE: cond_true_o = act_flags[`FL_PV];
            COND_P: cond_true_o = ~act_flags[`FL_SIGN];
            COND_M: cond_true_o = act_flags[`FL_SIGN];
        endcase
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;
    assign flags_o = act_flags;
    assign result_o = st_reg.result;
    assign bank_o = st_reg.bank;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [8:0] chk_sum;
    logic [4:0] chk_low;
    assign chk_sum = {1'b0, flag_op_i.a} + {1'b0, flag_op_i.b};
    assign chk_low = {1'b0, flag_op_i.a[3:0]} + {1'b0, flag_op_i.b[3:0]};

    sequence s_op(flag_op_e_t k);
        ce_i && flag_op_i.valid && (flag_op_i.op == k) && !flag_op_i.swap;
    endsequence

    a_add_carry: assert property (s_op(OP_ADD8) |=> flags_o[`FL_CARRY] == $past(chk_sum[8]))
        else $error("add carry wrong");
    a_add_half: assert property (s_op(OP_ADD8) |=> flags_o[`FL_HALF] == $past(chk_low[4]))
        else $error("add half-carry wrong");
    a_add_overflow: assert property (s_op(OP_ADD8) |=> (flags_o[`FL_PV]
        == $past((flag_op_i.a[7] == flag_op_i.b[7]) && (chk_sum[7] != flag_op_i.a[7])))
        && !flags_o[`FL_SUB]) else $error("add overflow or N wrong");
    a_sub_borrow: assert property (s_op(OP_SUB8) |=> flags_o[`FL_CARRY]
        == $past(flag_op_i.a < flag_op_i.b) && flags_o[`FL_SUB])
        else $error("subtract borrow wrong");
    a_or_zero: assert property (s_op(OP_OR8) |=> flags_o[`FL_ZERO]
        == $past((flag_op_i.a | flag_op_i.b) == 8'h00)) else $error("zero flag wrong");
    a_xor_sign: assert property (s_op(OP_XOR8) |=> flags_o[`FL_SIGN]
        == $past(flag_op_i.a[7] ^ flag_op_i.b[7])) else $error("sign flag wrong");
    a_and_flags: assert property (s_op(OP_AND8) |=> flags_o[`FL_HALF] && !flags_o[`FL_SUB]
        && !flags_o[`FL_CARRY] && flags_o[`FL_PV] == $past(~^(flag_op_i.a & flag_op_i.b)))
        else $error("logic flags wrong");
    a_idle_hold: assert property (ce_i && !flag_op_i.valid && !flag_op_i.swap && !bus_wr
        |=> flags_o == $past(flags_o)) else $error("flags moved without cause");
    a_blk_cmp: assert property (s_op(OP_BLK_CMP) |=> flags_o[`FL_SUB]
        && flags_o[`FL_CARRY] == $past(flags_o[`FL_CARRY])
        && flags_o[`FL_PV] == $past(flag_op_i.block_count_pair != 16'h0000))
        else $error("block compare flags wrong");
    a_blk_io: assert property (s_op(OP_BLK_IO) |=> flags_o[`FL_SUB]
        && flags_o[`FL_ZERO] == $past(flag_op_i.io_count == 8'h00))
        else $error("block io flags wrong");
    a_ld_latch: assert property (s_op(OP_LD_IR) |=> !flags_o[`FL_HALF] && !flags_o[`FL_SUB]
        && flags_o[`FL_PV] == $past(flag_op_i.interrupt_enable_latch))
        else $error("latch copy wrong");
    a_bit_test: assert property (s_op(OP_BIT) |=> flags_o[`FL_HALF]
        && flags_o[`FL_ZERO] == $past(~flag_op_i.b[flag_op_i.bit_sel]))
        else $error("bit test wrong");
    a_nibble_carry: assert property (s_op(OP_NIB_LEFT) |=> flags_o[`FL_CARRY]
        == $past(flags_o[`FL_CARRY])) else $error("nibble rotate changed carry");
    a_bank_swap: assert property (ce_i && flag_op_i.swap |=> bank_o != $past(bank_o))
        else $error("bank did not swap");
    a_cond_carry: assert property (s_op(OP_SCF) ##1 (cond_sel_i == COND_C) |-> cond_true_o)
        else $error("carry condition wrong");

endmodule : cpu_condition_flag_logic

// File: verif/cpu_condition_flag_logic_test.sv
// self-checking bench for the condition flag block
// assumes the block's design files and package are compiled first
module cpu_condition_flag_logic_test;
    import flag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cond_true, ce = 1;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, bus_d;
    logic ack, bank;
    logic [7:0] flags;
    logic [15:0] res;
    flag_op_t op = '0;
    cond_t csel = COND_NZ;
    int n_fail = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    cpu_condition_flag_logic DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .flag_op_i(op), .cond_sel_i(csel),
        .cond_true_o(cond_true), .flags_o(flags), .result_o(res), .bank_o(bank));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // ack and read data are taken as they stood at the rising edge that samples ack
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (!ack && i < 20);
        if (!ack) begin
            n_fail++;
            final_report();
        end
        bus_d = rdat;
        {cyc, stb, we} <= 3'b000;
        @(posedge clk_i);
    endtask : bus
    task automatic run(input flag_op_e_t o, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] expf);
        @(posedge clk_i);
        op.valid <= 1'b1;
        op.op <= o;
        op.a <= a;
        op.b <= b;
        @(posedge clk_i);
        op <= '0;
        #1;
        check(flags, expf);
    endtask : run
    // one expected outcome bit per branch condition code, checked against every code
    task automatic conds(input logic [7:0] exp);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_i);
            csel <= cond_t'(c);
            #1 check(cond_true, exp[c]);
        end
    endtask : conds
    task automatic t_arith();
        run(OP_ADD8, 8'h78, 8'h69, 8'h94);
        check(res[7:0], 8'he1);
        @(posedge clk_i);
        csel <= COND_C;
        run(OP_SCF, 8'h00, 8'h00, 8'h85);
        check(cond_true, 1'b1);
        run(OP_ADD8, 8'hfb, 8'hf0, 8'h81);
        run(OP_SUB8, 8'h00, 8'h01, 8'h93);
        conds(8'h99);
    endtask : t_arith
    task automatic t_logic();
        run(OP_AND8, 8'hf0, 8'h0f, 8'h54);
        conds(8'h66);
        run(OP_OR8, 8'h01, 8'h02, 8'h04);
        repeat (3) @(posedge clk_i);
        #1 check(flags, 8'h04);
        // a held clock enable must swallow the op
        @(posedge clk_i);
        ce <= 1'b0;
        op.valid <= 1'b1;
        op.op <= OP_SCF;
        @(posedge clk_i);
        ce <= 1'b1;
        op <= '0;
        #1 check(flags, 8'h04);
        run(OP_XOR8, 8'hff, 8'h80, 8'h00);
    endtask : t_logic
    task automatic t_special();
        run(OP_SUB8, 8'h00, 8'h01, 8'h93);
        @(posedge clk_i);
        op.block_count_pair <= 16'h0001;
        run(OP_BLK_CMP, 8'h5a, 8'h5a, 8'h47);
        @(posedge clk_i);
        op.io_count <= 8'h01;
        run(OP_BLK_IO, 8'h00, 8'h00, 8'h07);
        @(posedge clk_i);
        op.interrupt_enable_latch <= 1'b1;
        run(OP_LD_IR, 8'h00, 8'h80, 8'h85);
        @(posedge clk_i);
        op.bit_sel <= 3'h3;
        run(OP_BIT, 8'h00, 8'h00, 8'hd5);
    endtask : t_special
    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0);
        check(bus_d, 32'hd5);
        bus(1'b1, 4'h4, 32'hff);
        bus(1'b0, 4'h4, 32'h0);
        check(bus_d, 32'hd7);
        // swap rides on the op's own cycle only, else it toggles twice
        @(posedge clk_i);
        op.valid <= 1'b1;
        op.op <= OP_SCF;
        op.swap <= 1'b1;
        @(posedge clk_i);
        op <= '0;
        #1 check(flags, 8'hd7);
        check(bank, 1'b1);
        bus(1'b0, 4'h0, 32'h0);
        check(bus_d, 32'hc5);
        bus(1'b0, 4'h8, 32'h0);
        check(bus_d, 32'h1);
        bus(1'b0, 4'hc, 32'h0);
        check(bus_d, 32'h0);
    endtask : t_regs
    task automatic t_more();
        run(OP_NIB_LEFT, 8'h12, 8'h34, 8'h01);
        check(res, 16'h4213);
        @(posedge clk_i);
        op.rot <= ROT_SRA;
        run(OP_ROT_LOC, 8'h00, 8'h81, 8'h85);
        check(res, 16'h00c0);
        @(posedge clk_i);
        op.a16 <= 16'h7fff;
        run(OP_ADC16, 8'h00, 8'h00, 8'h84);
        check(res, 16'h8000);
        @(posedge clk_i);
        op.b16 <= 16'h0001;
        run(OP_SBC16, 8'h00, 8'h00, 8'h83);
        check(res, 16'hffff);
        run(OP_CP8, 8'h20, 8'h10, 8'h02);
        check(res, 16'h0020);
    endtask : t_more
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_arith();
        t_logic();
        t_special();
        t_regs();
        t_more();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        final_report();
    end
endmodule : cpu_condition_flag_logic_test
